// [irq_source_latch.sv]
// Raw interrupt source bits: sticky events and mirrored levels.
// Assumes one clock, synchronous active-low reset, same-clock inputs.
`timescale 1ns/1ps
`include "usb_irq_defs.svh"
module irq_source_latch (
  input  wire logic      aclk,
  input  wire logic      aresetn,
  irq_src_if.latch       src
);
  localparam usb_irq_pkg::src_vec_t LEVEL_KIND = `LEVEL_SRC_MASK;

  usb_irq_pkg::src_vec_t raw_r;

  // ----------------------------------------------------------------
  // One flop per source
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < `IRQ_SRC_W; i = i + 1) begin : g_src
      if (LEVEL_KIND[i]) begin : g_level
        always_ff @(posedge aclk) begin
          if (!aresetn) begin
            raw_r[i] <= 1'b0;
          end else begin
            raw_r[i] <= src.level_in[i];
          end
        end
      end else begin : g_event
        // Set wins over a clear in the same cycle
        always_ff @(posedge aclk) begin
          if (!aresetn) begin
            raw_r[i] <= 1'b0;
          end else begin
            raw_r[i] <= src.set_ev[i] | (raw_r[i] & ~src.clr_ev[i]);
          end
        end
      end
    end
  endgenerate

  assign src.raw = raw_r;
endmodule

// [irq_src_if.sv]
// Carrier between the register side and the source latches.
// Assumes usb_irq_pkg is compiled first.
`timescale 1ns/1ps
interface irq_src_if;
  usb_irq_pkg::src_vec_t set_ev;
  usb_irq_pkg::src_vec_t clr_ev;
  usb_irq_pkg::src_vec_t level_in;
  usb_irq_pkg::src_vec_t raw;
  modport former (output set_ev, output clr_ev, output level_in, input raw);
  modport latch  (input set_ev, input clr_ev, input level_in, output raw);
endinterface

// [usb_irq_defs.svh]
// Constants for the USB interrupt enable and force block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef USB_IRQ_DEFS_SVH
`define USB_IRQ_DEFS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define IRQ_SRC_W        20
`define DATA_W           32
`define STRB_W           4
`define ADDR_W           8
`define EP_VEC_W         32
`define SPEED_W          2

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_RAW          8'h8c
`define OFS_ENABLE       8'h90
`define OFS_FORCE        8'h94
`define OFS_FINAL        8'h98

// ----------------------------------------------------------------
// Reset values, source kinds and bus answers
// ----------------------------------------------------------------
`define ENABLE_RST       20'h00000
`define FORCE_RST        20'h00000
`define SRC_RST          20'h00000
`define LEVEL_SRC_MASK   20'hd1ff0
`define W1C_SRC_MASK     20'h00008
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

// ----------------------------------------------------------------
// Source bit positions
// ----------------------------------------------------------------
`define BIT_EP_HANDSHAKE 19
`define BIT_ABORT_DONE   18
`define BIT_FRAME_START_RECEIVED      17
`define BIT_SETUP        16
`define BIT_DEV_WAKE     15
`define BIT_DEV_SLEEP    14
`define BIT_DEV_ATTACH   13
`define BIT_BUS_RESET    12
`define BIT_BUS_POWER    11
`define BIT_HALT         10
`define BIT_CRC          9
`define BIT_STUFF        8
`define BIT_RX_OVF       7
`define BIT_RX_TMO       6
`define BIT_TOGGLE       5
`define BIT_BUF_DONE     4
`define BIT_XFER_DONE    3
`define BIT_HOST_SOF     2
`define BIT_HOST_WAKE    1
`define BIT_HOST_ATTACH  0

`endif

// [usb_irq_enable_force.sv]
// Interrupt enable and force logic of a dual-role USB controller.
// Assumes all status inputs come from logic on aclk; AXI4-Lite slave.
`timescale 1ns/1ps
`include "usb_irq_defs.svh"

// How it works
// R1 - Enable mask at 0x90, bits 19:0 read-write, reset zero, 31:20 reserved.
// R2 - Force mask at 0x94, same layout, read-write, reset zero.
// R3 - Bit 19 high while any endpoint stall/NAK vector bit is set.
// R4 - Bit 18 high while any endpoint abort-finished vector bit is set.
// R5 - Bit 17 set on device-role frame start, cleared by frame-number read.
// R6 - Bits 16,12..5 mirror the serial engine status flags.
// R7 - Bit 15 set on device wake from host, cleared by resume flag write.
// R8 - Bit 14 set on device sleep state change, cleared by sleep flag write.
// R9 - Bit 13 set on device attach change, cleared by attach flag write.
// R10 - Bit 4 high while any endpoint buffer status bit is set.
// R11 - Bit 3 set on each transfer finish, cleared by writing one to it.
// R12 - Bit 2 set on host-role frame start sent, cleared by frame-number read.
// R13 - Bit 1 set when a device wakes the host, cleared by resume flag write.
// R14 - Bit 0 set on host line speed change, cleared by speed field write.
// R15 - Final status is raw AND enable, OR force, per bit.
// R16 - One interrupt output high while any final status bit is set.
// R17 - A set force bit holds its status bit until written back to zero.
module usb_irq_enable_force (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // AXI4-Lite slave
  input  wire logic [`ADDR_W-1:0]     awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [`DATA_W-1:0]     wdata,
  input  wire logic [`STRB_W-1:0]     wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [`ADDR_W-1:0]     araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [`DATA_W-1:0]          rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  // Controller status
  input  wire logic                   host_mode,
  input  wire logic [`EP_VEC_W-1:0]   endpoint_handshake_vector,
  input  wire logic [`EP_VEC_W-1:0]   abort_done_vector,
  input  wire logic [`EP_VEC_W-1:0]   endpoint_buffer_done,
  input  wire logic                   frame_start_received,
  input  wire logic                   host_frame_sent,
  input  wire logic                   frame_number_read,
  input  wire logic                   setup_packet_seen,
  input  wire logic                   bus_reset_flag,
  input  wire logic                   bus_power_present,
  input  wire logic                   halt_handshake_seen,
  input  wire logic                   crc_fault_flag,
  input  wire logic                   stuffing_fault_flag,
  input  wire logic                   rx_overflow_flag,
  input  wire logic                   rx_timeout_flag,
  input  wire logic                   toggle_mismatch_flag,
  input  wire logic                   wakeup_from_upstream,
  input  wire logic                   downstream_wakeup,
  input  wire logic                   resume_flag_write,
  input  wire logic                   sleep_state_flag,
  input  wire logic                   sleep_flag_write,
  input  wire logic                   attach_state_flag,
  input  wire logic                   attach_flag_write,
  input  wire logic                   transfer_finished,
  input  wire logic [`SPEED_W-1:0]    line_speed,
  input  wire logic                   speed_field_write,
  // Interrupt result
  output logic [`IRQ_SRC_W-1:0]       usb_irq_final_status,
  output logic                        irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  irq_src_if src ();

  logic                    aw_held_r;
  logic [`ADDR_W-1:0]      awaddr_r;
  logic                    w_held_r;
  logic [`DATA_W-1:0]      wdata_r;
  logic [`STRB_W-1:0]      wstrb_r;
  logic                    bvalid_r;
  usb_irq_pkg::axi_resp_t  bresp_r;
  logic                    rvalid_r;
  usb_irq_pkg::axi_resp_t  rresp_r;
  usb_irq_pkg::word_t      rdata_r;

  usb_irq_pkg::src_vec_t   usb_irq_enable_mask_r;
  usb_irq_pkg::src_vec_t   usb_irq_enable_mask_nxt;
  usb_irq_pkg::src_vec_t   usb_irq_force_mask_r;
  usb_irq_pkg::src_vec_t   usb_irq_force_mask_nxt;
  usb_irq_pkg::src_vec_t   final_r;
  usb_irq_pkg::src_vec_t   final_nxt;
  logic                    irq_r;

  logic                    sleep_prev_r;
  logic                    attach_prev_r;
  logic [`SPEED_W-1:0]     speed_prev_r;
  logic                    primed_r;

  logic                    aw_take;
  logic                    w_take;
  logic                    ar_take;
  logic                    wr_fire;
  logic                    wr_hit_raw;
  logic                    wr_hit_enable;
  logic                    wr_hit_force;
  logic                    wr_hit_final;
  logic                    wr_mapped;
  logic                    rd_hit_raw;
  logic                    rd_hit_enable;
  logic                    rd_hit_force;
  logic                    rd_hit_final;
  logic                    rd_mapped;
  usb_irq_pkg::word_t      wmask;
  usb_irq_pkg::src_vec_t   wmask_src;
  usb_irq_pkg::src_vec_t   wdata_src;
  usb_irq_pkg::src_vec_t   raw_w1c;
  usb_irq_pkg::word_t      rd_word;
  usb_irq_pkg::src_vec_t   rd_src;
  usb_irq_pkg::src_vec_t   set_vec;
  usb_irq_pkg::src_vec_t   clr_vec;
  usb_irq_pkg::src_vec_t   level_vec;
  logic                    sleep_change;
  logic                    attach_change;
  logic                    speed_change;
  logic                    dev_mode;

  // ----------------------------------------------------------------
  // Write channel handshake
  // ----------------------------------------------------------------
  assign awready = ~aw_held_r & ~bvalid_r;
  assign wready  = ~w_held_r & ~bvalid_r;
  assign aw_take = awvalid & awready;
  assign w_take  = wvalid & wready;
  assign wr_fire = aw_held_r & w_held_r & ~bvalid_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= '0;
    end else if (aw_take) begin
      aw_held_r <= 1'b1;
      awaddr_r  <= awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end else if (w_take) begin
      w_held_r <= 1'b1;
      wdata_r  <= wdata;
      wstrb_r  <= wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Write decode and byte lanes
  // ----------------------------------------------------------------
  assign wr_hit_raw    = awaddr_r == `OFS_RAW;
  assign wr_hit_enable = awaddr_r == `OFS_ENABLE;
  assign wr_hit_force  = awaddr_r == `OFS_FORCE;
  assign wr_hit_final  = awaddr_r == `OFS_FINAL;
  assign wr_mapped     = wr_hit_raw | wr_hit_enable | wr_hit_force | wr_hit_final;
  assign wmask         = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign wmask_src     = wmask[`IRQ_SRC_W-1:0];
  assign wdata_src     = wdata_r[`IRQ_SRC_W-1:0];

  // Only the transfer-finished bit of the raw word is writable
  assign raw_w1c = (wr_fire & wr_hit_raw) ? (wdata_src & wmask_src & `W1C_SRC_MASK)
                                          : `SRC_RST; // R11

  assign usb_irq_enable_mask_nxt = (wr_fire & wr_hit_enable)
      ? ((usb_irq_enable_mask_r & ~wmask_src) | (wdata_src & wmask_src))
      : usb_irq_enable_mask_r; // R1
  assign usb_irq_force_mask_nxt = (wr_fire & wr_hit_force)
      ? ((usb_irq_force_mask_r & ~wmask_src) | (wdata_src & wmask_src))
      : usb_irq_force_mask_r; // R2 R17

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usb_irq_enable_mask_r <= `ENABLE_RST; // R1
      usb_irq_force_mask_r  <= `FORCE_RST; // R2
    end else begin
      usb_irq_enable_mask_r <= usb_irq_enable_mask_nxt;
      usb_irq_force_mask_r  <= usb_irq_force_mask_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign arready       = ~rvalid_r;
  assign ar_take       = arvalid & arready;
  assign rd_hit_raw    = araddr == `OFS_RAW;
  assign rd_hit_enable = araddr == `OFS_ENABLE;
  assign rd_hit_force  = araddr == `OFS_FORCE;
  assign rd_hit_final  = araddr == `OFS_FINAL;
  assign rd_mapped     = rd_hit_raw | rd_hit_enable | rd_hit_force | rd_hit_final;
  assign rd_src = rd_hit_raw    ? src.raw :
                  rd_hit_enable ? usb_irq_enable_mask_r :
                  rd_hit_force  ? usb_irq_force_mask_r :
                  rd_hit_final  ? final_r : `SRC_RST;
  // Reserved upper bits read as zero
  assign rd_word = {{(`DATA_W-`IRQ_SRC_W){1'b0}}, rd_src}; // R1 R2
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= `RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_word;
      rresp_r  <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State change detection
  // ----------------------------------------------------------------
  // First cycle after reset only loads history, no false change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      primed_r      <= 1'b0;
      sleep_prev_r  <= 1'b0;
      attach_prev_r <= 1'b0;
      speed_prev_r  <= '0;
    end else begin
      primed_r      <= 1'b1;
      sleep_prev_r  <= sleep_state_flag;
      attach_prev_r <= attach_state_flag;
      speed_prev_r  <= line_speed;
    end
  end

  assign dev_mode      = ~host_mode;
  assign sleep_change  = primed_r & (sleep_state_flag != sleep_prev_r);
  assign attach_change = primed_r & (attach_state_flag != attach_prev_r);
  assign speed_change  = primed_r & (line_speed != speed_prev_r);

  // ----------------------------------------------------------------
  // Source forming
  // ----------------------------------------------------------------
  always_comb begin
    set_vec   = `SRC_RST;
    clr_vec   = `SRC_RST;
    level_vec = `SRC_RST;
    level_vec[`BIT_EP_HANDSHAKE] = |endpoint_handshake_vector; // R3
    level_vec[`BIT_ABORT_DONE]   = |abort_done_vector; // R4
    level_vec[`BIT_SETUP]        = setup_packet_seen; // R6
    level_vec[`BIT_BUS_RESET]    = bus_reset_flag; // R6
    level_vec[`BIT_BUS_POWER]    = bus_power_present; // R6
    level_vec[`BIT_HALT]         = halt_handshake_seen; // R6
    level_vec[`BIT_CRC]          = crc_fault_flag; // R6
    level_vec[`BIT_STUFF]        = stuffing_fault_flag; // R6
    level_vec[`BIT_RX_OVF]       = rx_overflow_flag; // R6
    level_vec[`BIT_RX_TMO]       = rx_timeout_flag; // R6
    level_vec[`BIT_TOGGLE]       = toggle_mismatch_flag; // R6
    level_vec[`BIT_BUF_DONE]     = |endpoint_buffer_done; // R10
    set_vec[`BIT_FRAME_START_RECEIVED]        = dev_mode & frame_start_received; // R5
    clr_vec[`BIT_FRAME_START_RECEIVED]        = frame_number_read; // R5
    set_vec[`BIT_DEV_WAKE]       = dev_mode & wakeup_from_upstream; // R7
    clr_vec[`BIT_DEV_WAKE]       = resume_flag_write; // R7
    set_vec[`BIT_DEV_SLEEP]      = dev_mode & sleep_change; // R8
    clr_vec[`BIT_DEV_SLEEP]      = sleep_flag_write; // R8
    set_vec[`BIT_DEV_ATTACH]     = dev_mode & attach_change; // R9
    clr_vec[`BIT_DEV_ATTACH]     = attach_flag_write; // R9
    set_vec[`BIT_XFER_DONE]      = transfer_finished; // R11
    clr_vec[`BIT_XFER_DONE]      = raw_w1c[`BIT_XFER_DONE]; // R11
    set_vec[`BIT_HOST_SOF]       = host_mode & host_frame_sent; // R12
    clr_vec[`BIT_HOST_SOF]       = frame_number_read; // R12
    set_vec[`BIT_HOST_WAKE]      = host_mode & downstream_wakeup; // R13
    clr_vec[`BIT_HOST_WAKE]      = resume_flag_write; // R13
    set_vec[`BIT_HOST_ATTACH]    = host_mode & speed_change; // R14
    clr_vec[`BIT_HOST_ATTACH]    = speed_field_write; // R14
  end

  assign src.set_ev   = set_vec;
  assign src.clr_ev   = clr_vec;
  assign src.level_in = level_vec;

  irq_source_latch u_latch (
    .aclk    (aclk),
    .aresetn (aresetn),
    .src     (src.latch)
  );

  // ----------------------------------------------------------------
  // Masking, forcing and request output
  // ----------------------------------------------------------------
  assign final_nxt = (src.raw & usb_irq_enable_mask_r) | usb_irq_force_mask_r; // R15 R17

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      final_r <= `SRC_RST;
      irq_r   <= 1'b0;
    end else begin
      final_r <= final_nxt; // R15
      irq_r   <= |final_nxt; // R16
    end
  end

  assign usb_irq_final_status = final_r;
  assign irq                  = irq_r;

endmodule

// [usb_irq_enable_force_checker.sv]
// Concurrent checks on the bus and interrupt ports of the enable/force block.
// Assumes it is bound into usb_irq_enable_force; one clock, synchronous reset.
`timescale 1ns/1ps
`include "usb_irq_defs.svh"
module usb_irq_enable_force_checker (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  awready,
  input wire logic                  wready,
  input wire logic                  bvalid,
  input wire logic                  bready,
  input wire logic [`ADDR_W-1:0]    araddr,
  input wire logic                  arvalid,
  input wire logic                  arready,
  input wire logic [`DATA_W-1:0]    rdata,
  input wire logic [1:0]            rresp,
  input wire logic                  rvalid,
  input wire logic                  rready,
  input wire logic [`IRQ_SRC_W-1:0] usb_irq_final_status,
  input wire logic                  irq
);
  // ----
  // Decode
  // ----
  wire logic rd_map  = araddr == `OFS_RAW || araddr == `OFS_ENABLE ||
                       araddr == `OFS_FORCE || araddr == `OFS_FINAL;
  wire logic rd_take = arvalid && arready;

  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----
  // Assertions
  // ----
  property p_irq_or; irq == |usb_irq_final_status; endproperty
  a_irq_or: assert property (p_irq_or)
    else $error("irq differs from final status");
  property p_reset; $rose(aresetn) |-> usb_irq_final_status == 20'h00000 && !irq; endproperty
  a_reset: assert property (p_reset)
    else $error("status not clear after reset");
  property p_rsv_zero; rvalid |-> rdata[31:20] == 12'h000; endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("reserved read bits set");
  property p_rd_ans; rd_take |=> rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered");
  property p_rd_done; rvalid && rready |=> !rvalid; endproperty
  a_rd_done: assert property (p_rd_done)
    else $error("read answer not released");
  property p_bad_rd; rd_take && !rd_map |=> rresp == `RESP_SLVERR && rdata == 32'h0; endproperty
  a_bad_rd: assert property (p_bad_rd)
    else $error("unmapped read not refused");
  property p_good_rd; rd_take && rd_map |=> rresp == `RESP_OKAY; endproperty
  a_good_rd: assert property (p_good_rd)
    else $error("mapped read refused");
  property p_wr_busy; bvalid |-> !awready && !wready; endproperty
  a_wr_busy: assert property (p_wr_busy)
    else $error("write accepted while answering");
  property p_b_done; bvalid && bready |=> !bvalid; endproperty
  a_b_done: assert property (p_b_done)
    else $error("write answer not released");
endmodule

// [usb_irq_enable_force_tb_top.sv]
// Self-checking bench for the interrupt enable and force block.
// Assumes design files and checker compile first; bench drives all ports.
`timescale 1ns/1ps
`include "usb_irq_defs.svh"
module usb_irq_enable_force_tb_top;
  logic                  aclk = 1'b0;
  logic                  aresetn = 1'b0;
  logic [7:0]            awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]           wdata = 32'h0, rdata, vec = 32'h1;
  logic [3:0]            wstrb = 4'h0;
  logic                  awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic                  awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]            bresp, rresp, sp = 2'h0;
  logic [11:0]           lv = 12'h0;
  logic [4:0]            ev = 5'h0, cl = 5'h0;
  logic                  hm = 1'b0, sl = 1'b0, at = 1'b0;
  logic [7:0]            erole = 8'h8a;
  usb_irq_pkg::src_vec_t final_status, men, mfr, mraw;
  int                    err_count = 0, n_checks = 0, n_tests = 0;
  int                    lbit[12] = '{19, 18, 4, 16, 12, 11, 10, 9, 8, 7, 6, 5};
  int                    ebit[8] = '{17, 2, 15, 1, 3, 14, 13, 0};
  int                    ecl[8] = '{0, 0, 1, 1, 0, 2, 3, 4};

  always #20 aclk = ~aclk;

  usb_irq_enable_force usb_irq_enable_force_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .host_mode(hm), .endpoint_handshake_vector(lv[0] ? vec : 32'h0),
    .abort_done_vector(lv[1] ? vec : 32'h0), .endpoint_buffer_done(lv[2] ? vec : 32'h0),
    .frame_start_received(ev[0]), .host_frame_sent(ev[1]), .frame_number_read(cl[0]),
    .setup_packet_seen(lv[3]), .bus_reset_flag(lv[4]), .bus_power_present(lv[5]),
    .halt_handshake_seen(lv[6]), .crc_fault_flag(lv[7]), .stuffing_fault_flag(lv[8]),
    .rx_overflow_flag(lv[9]), .rx_timeout_flag(lv[10]), .toggle_mismatch_flag(lv[11]),
    .wakeup_from_upstream(ev[2]), .downstream_wakeup(ev[3]), .resume_flag_write(cl[1]),
    .sleep_state_flag(sl), .sleep_flag_write(cl[2]), .attach_state_flag(at),
    .attach_flag_write(cl[3]), .transfer_finished(ev[4]), .line_speed(sp),
    .speed_field_write(cl[4]), .usb_irq_final_status(final_status), .irq(irq)
  );

  // ----
  // Model and reporting
  // ----
  function automatic usb_irq_pkg::src_vec_t fin();
    return (mraw & men) | mfr;
  endfunction
  function automatic usb_irq_pkg::src_vec_t lraw(logic [11:0] l);
    usb_irq_pkg::src_vec_t r;
    r = '0;
    for (int i = 0; i < 12; i++) if (l[i]) r[lbit[i]] = 1'b1;
    return r;
  endfunction
  function automatic usb_irq_pkg::src_vec_t mrg(usb_irq_pkg::src_vec_t o,
                                                logic [31:0] d, logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return 20'(({12'h0, o} & ~m) | (d & m));
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("Tests %0d, checks %0d, mismatches %0d", n_tests, n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic endt(input string s);
    n_tests++;
    $display("Test %s finished", s);
  endtask
  task automatic alive(input bit g);
    chk({31'h0, g}, 32'h1);
    if (!g) summarize();
  endtask

  // ----
  // Bus and source drivers
  // ----
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic [1:0] r;
    bit         ap;
    bit         wp;
    bit         g;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ap = 1'b1;
    wp = 1'b1;
    g = 1'b0;
    for (int t = 0; t < 50 && !g; t++) begin
      @(posedge aclk);
      if (ap && awready === 1'b1) begin
        ap = 1'b0;
        awvalid <= 1'b0;
      end
      if (wp && wready === 1'b1) begin
        wp = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        g = 1'b1;
        r = bresp;
      end
    end
    bready <= 1'b0;
    alive(g);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    bit          ap;
    bit          g;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ap = 1'b1;
    g = 1'b0;
    for (int t = 0; t < 50 && !g; t++) begin
      @(posedge aclk);
      if (ap && arready === 1'b1) begin
        ap = 1'b0;
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        g = 1'b1;
        d = rdata;
        r = rresp;
      end
    end
    rready <= 1'b0;
    alive(g);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic look();
    repeat (3) @(posedge aclk);
    rd(`OFS_FINAL, {12'h0, fin()}, `RESP_OKAY);
    rd(`OFS_RAW, {12'h0, mraw}, `RESP_OKAY);
    chk({31'h0, irq}, {31'h0, |fin()});
  endtask
  task automatic fire(input int i, input bit h);
    @(posedge aclk);
    hm <= h;
    if (i < 5) ev[i] <= 1'b1;
    else if (i == 5) sl <= ~sl;
    else if (i == 6) at <= ~at;
    else sp <= sp + 2'h1;
    @(posedge aclk);
    ev <= 5'h0;
  endtask
  task automatic rst();
    aresetn <= 1'b0;
    lv <= 12'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    men = '0;
    mfr = '0;
    mraw = '0;
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    logic [31:0] d;
    logic [11:0] l;
    logic [7:0]  a;
    void'($urandom(32'hab83615a));
    rst();
    rd(`OFS_ENABLE, 32'h0, `RESP_OKAY);
    rd(`OFS_FORCE, 32'h0, `RESP_OKAY);
    look();
    endt("reset values");
    for (int k = 0; k < 6; k++) begin
      d = $urandom();
      l = (k == 0) ? 12'hf : 12'($urandom());
      a = k[0] ? `OFS_FORCE : `OFS_ENABLE;
      wr(a, d, l[3:0], `RESP_OKAY);
      if (k[0]) mfr = mrg(mfr, d, l[3:0]);
      else men = mrg(men, d, l[3:0]);
      rd(a, {12'h0, k[0] ? mfr : men}, `RESP_OKAY);
    end
    look();
    wr(`OFS_FINAL, 32'hffffffff, 4'hf, `RESP_OKAY);
    wr(8'ha0, 32'hffffffff, 4'hf, `RESP_SLVERR);
    rd(8'ha0, 32'h0, `RESP_SLVERR);
    look();
    endt("registers");
    wr(`OFS_FORCE, 32'h0, 4'hf, `RESP_OKAY);
    wr(`OFS_ENABLE, 32'hfffff, 4'hf, `RESP_OKAY);
    mfr = '0;
    men = 20'hfffff;
    for (int i = 0; i < 12; i++) begin
      lv <= 12'h1 << i;
      vec <= 32'h1 << ($urandom() % 32);
      mraw = lraw(12'h1 << i);
      look();
      lv <= 12'h0;
      mraw = '0;
      look();
    end
    endt("level sources");
    for (int i = 0; i < 8; i++) begin
      if (i != 4) fire(i, !erole[i]);
      look();
      fire(i, erole[i]);
      mraw[ebit[i]] = 1'b1;
      look();
      if (i == 4) wr(`OFS_RAW, 32'h8, 4'h1, `RESP_OKAY);
      else fire_clear(ecl[i]);
      mraw[ebit[i]] = 1'b0;
      look();
    end
    endt("event sources");
    for (int k = 0; k < 4; k++) begin
      d = $urandom();
      wr(`OFS_ENABLE, d, 4'hf, `RESP_OKAY);
      men = 20'(d);
      d = $urandom();
      wr(`OFS_FORCE, d, 4'hf, `RESP_OKAY);
      mfr = 20'(d);
      l = 12'($urandom());
      lv <= l;
      mraw = lraw(l);
      look();
    end
    endt("mask and force");
    rst();
    rd(`OFS_ENABLE, 32'h0, `RESP_OKAY);
    rd(`OFS_FORCE, 32'h0, `RESP_OKAY);
    look();
    endt("second reset");
    summarize();
  end
  task automatic fire_clear(input int c);
    @(posedge aclk);
    cl[c] <= 1'b1;
    @(posedge aclk);
    cl <= 5'h0;
  endtask
endmodule

bind usb_irq_enable_force usb_irq_enable_force_checker checker_inst (
  .aclk(aclk), .aresetn(aresetn), .awready(awready), .wready(wready), .bvalid(bvalid),
  .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .usb_irq_final_status(usb_irq_final_status), .irq(irq)
);

// [usb_irq_pkg.sv]
// Types shared by the USB interrupt enable and force block.
// Assumes usb_irq_defs.svh is on the include path.
`include "usb_irq_defs.svh"
package usb_irq_pkg;
  typedef logic [`IRQ_SRC_W-1:0] src_vec_t;
  typedef logic [1:0]            axi_resp_t;
  typedef logic [`DATA_W-1:0]    word_t;
endpackage
